// *** rtl/pll_lock_and_vco_calibration_control.sv ***
// Purpose: register file, configuration decode and vco calibration sequencer
// Assumes: all pins synchronous to clk_sys; divider clocks slower than clk_sys/2
// Notes:   calibration length is counted in input divider (pfd) periods
`include "pll_ctrl_cfg.svh"
module pll_lock_and_vco_calibration_control
   import pll_ctrl_pkg::*;
#(
   parameter int CAL_CYCLES = `CAL_PFD_CYCLES,
   parameter int LOCK_COUNT = `LOCK_COUNT_DEF
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // register port
   input  wire logic [`ADDR_W-1:0] addr,
   input  wire logic [31:0]       wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [31:0]       rdata,
   // nonvolatile memory load
   output logic                   eeprom_reload,
   input  wire logic              load_done,
   input  wire logic [31:0]       eeprom_word0,
   input  wire logic [31:0]       eeprom_word1,
   input  wire logic [31:0]       eeprom_word2,
   // clock status and divider clocks
   input  wire logic              ref_present,
   input  wire logic              ref_div,
   input  wire logic              fb_div,
   // external power-down pin, active low
   input  wire logic              power_down_pin_n,
   // analog configuration and status
   output logic                   vco_range_select,
   output logic      [2:0]        prescale_ratio,
   output logic                   lf_internal,
   output logic      [1:0]        cp_current_sel,
   output logic      [1:0]        lf_rc_group,
   output logic      [1:0]        lock_window_code,
   output logic                   out_enable,
   output logic                   cal_active,
   output logic                   lock_pin
);
   localparam int CAL_W = 12;
   initial begin
      if (CAL_CYCLES < 2 || CAL_CYCLES > 4095) $error("CAL_CYCLES out of range");
   end

   // prescaler select {high,low}: 00->5, 10->4, 01->3, 11->2
   function automatic logic [2:0] presc_ratio(input logic sel_high, input logic sel_low);
      presc_ratio = 3'h5 - {2'h0, sel_high} - {1'b0, sel_low, 1'b0};
   endfunction

   // loop filter code: 0-3 internal, 4-15 external with rc group in upper bits
   function automatic lf_cfg_s lf_decode(input logic [3:0] code);
      lf_decode.internal = (code[3:2] == 2'h0);
      lf_decode.cp_sel   = code[1:0];
      lf_decode.rc_group = code[3:2];
   endfunction

   // address match for one aligned word
   function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [1:0] idx);
      hit = (a[`ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
   endfunction

   logic [31:0]      reg0;          // lock window
   logic [31:0]      reg1;          // vco, prescaler, loop filter
   logic [31:0]      reg2;          // calibration control, lock status
   cal_state_e       state;         // sequencer state
   cal_state_e       next_state;
   logic [CAL_W-1:0] cal_cnt;       // pfd periods into calibration
   logic             ref_prev;      // divider edge detection
   logic             fb_prev;
   logic             rst_bit_prev;  // previous restart bit
   logic             pwr_bit_prev;  // previous power-down bit
   logic             pin_prev;      // previous pin level
   logic             pin_low_seen;  // pin went low since last rise

   lock_if lk ();

   // field views of the control bits
   wire logic src_bit   = reg2[`B2_SRC];
   wire logic pwr_bit   = reg2[`B2_PWR];
   wire logic rst_bit   = reg2[`B2_RST];
   wire logic ref_edge  = ref_div && !ref_prev;
   wire logic fb_edge   = fb_div && !fb_prev;
   // edge detection so each transition starts one sequence only
   wire logic restart_rise = rst_bit && !rst_bit_prev;
   wire logic pwr_fall     = !pwr_bit && pwr_bit_prev;
   wire logic pwr_rise     = pwr_bit && !pwr_bit_prev;
   wire logic cal_req_sw   = src_bit && pwr_bit && restart_rise;
   wire logic sleep_req    = !src_bit && pwr_fall;
   wire logic wake_req     = !src_bit && pwr_rise;
   wire logic pin_rise     = power_down_pin_n && !pin_prev && pin_low_seen;
   wire logic load_take    = eeprom_reload && load_done;
   wire logic cal_last     = ref_edge && (cal_cnt == CAL_W'(CAL_CYCLES - 1));
   wire lf_cfg_s lf        = lf_decode(reg1[`B1_LF_MSB:`B1_LF_LSB]);
   wire logic hit0         = hit(addr, `REG_IDX_0);
   wire logic hit1         = hit(addr, `REG_IDX_1);
   wire logic hit2         = hit(addr, `REG_IDX_2);
   wire logic [31:0] reg2_view = {reg2[31:`B2_LOCK+1], lock_pin, reg2[`B2_LOCK-1:0]};
   wire logic [31:0] rd_mux = hit0 ? reg0 : hit1 ? reg1 : hit2 ? reg2_view : 32'h0000_0000;

   // carrier to the detector; held clear unless the loop is running
   assign lk.ref_edge = ref_edge;
   assign lk.fb_edge  = fb_edge;
   assign lk.win_code = {reg0[`B0_WIN_HI], reg0[`B0_WIN_LO]};
   assign lk.clear    = (state != ST_RUN);

   lock_detector #(
      .LOCK_COUNT (LOCK_COUNT)
   ) u_lock (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .lk      (lk.det)
   );

   // sequencer transitions; the pin overrides everything while low
   always_comb begin
      next_state = state;
      if (!power_down_pin_n) begin
         next_state = ST_WAIT_LOAD;
      end else begin
         case (state)
            ST_WAIT_LOAD: begin
               // a pin pulse in the load cycle asks again, so that load is not trusted
               if (load_take && !pin_rise) next_state = ST_WAIT_REF;
            end
            ST_WAIT_REF: begin
               if (ref_present) next_state = ST_CAL;
            end
            ST_CAL: begin
               if (cal_last) next_state = ST_RUN;
            end
            ST_RUN: begin
               // setting changes alone never recalibrate; the host asks
               if (sleep_req) next_state = ST_POWERDOWN;
               else if (cal_req_sw) next_state = ST_CAL;
            end
            ST_POWERDOWN: begin
               if (wake_req) next_state = ST_WAIT_REF;
            end
            default: next_state = ST_WAIT_LOAD;
         endcase
      end
   end

   // state, calibration counter and edge history
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state        <= ST_WAIT_LOAD;
         cal_cnt      <= '0;
         ref_prev     <= 1'b0;
         fb_prev      <= 1'b0;
         rst_bit_prev <= 1'b0;
         pwr_bit_prev <= 1'b1;
         pin_prev     <= 1'b1;
         pin_low_seen <= 1'b0;
      end else begin
         state        <= next_state;
         cal_cnt      <= (state != ST_CAL) ? '0 : (ref_edge ? cal_cnt + CAL_W'(1) : cal_cnt);
         ref_prev     <= ref_div;
         fb_prev      <= fb_div;
         rst_bit_prev <= rst_bit;
         pwr_bit_prev <= pwr_bit;
         pin_prev     <= power_down_pin_n;
         pin_low_seen <= power_down_pin_n ? (pin_low_seen && !pin_rise) : 1'b1;
      end
   end

   // register file: memory load wins over a bus write in the same cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg0 <= `REG0_RST;
         reg1 <= `REG1_RST;
         reg2 <= `REG2_RST;
      end else if (load_take) begin
         reg0 <= eeprom_word0;
         reg1 <= eeprom_word1;
         reg2 <= eeprom_word2 & ~(32'h1 << `B2_SRC);
      end else if (wr) begin
         if (hit0) reg0 <= wdata;
         if (hit1) reg1 <= wdata;
         if (hit2) reg2 <= wdata;
      end
   end

   // reload request: raised at power-up and on a pin pulse, dropped when served
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         eeprom_reload <= 1'b1;
      end else if (pin_rise) begin
         eeprom_reload <= 1'b1;
      end else if (load_done) begin
         eeprom_reload <= 1'b0;
      end
   end

   // read data stands for exactly the cycle after the strobe
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= rd ? rd_mux : 32'h0000_0000;
      end
   end

   // registered configuration and status outputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         vco_range_select <= 1'b0;
         prescale_ratio   <= 3'h5;
         lf_internal      <= 1'b1;
         cp_current_sel   <= 2'h0;
         lf_rc_group      <= 2'h0;
         lock_window_code <= 2'h0;
         out_enable       <= 1'b0;
         cal_active       <= 1'b0;
         lock_pin         <= 1'b0;
      end else begin
         vco_range_select <= reg1[`B1_VCO];
         prescale_ratio   <= presc_ratio(reg1[`B1_PRESC_B], reg1[`B1_PRESC_A]);
         lf_internal      <= lf.internal;
         cp_current_sel   <= lf.cp_sel;
         lf_rc_group      <= lf.rc_group;
         lock_window_code <= lk.win_code;
         // outputs only in run: off during calibration and power-down
         out_enable       <= (next_state == ST_RUN);
         cal_active       <= (next_state == ST_CAL);
         lock_pin         <= lk.locked;
      end
   end

   sequence sw_restart;
      state == ST_RUN && cal_req_sw && !sleep_req && power_down_pin_n;
   endsequence
   sequence bit_wake;
      state == ST_POWERDOWN && wake_req && power_down_pin_n && ref_present ##1 ref_present && power_down_pin_n;
   endsequence

   a_restart_cal: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sw_restart |=> cal_active && !out_enable)
      else $error("restart edge did not start calibration");
   a_sleep_outputs_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state == ST_POWERDOWN |-> !out_enable && !cal_active)
      else $error("outputs on during power-down");
   a_wake_cal: assert property (@(posedge clk_sys) disable iff (!rst_n) bit_wake |=> cal_active)
      else $error("power-down release did not calibrate");
   a_wait_ref: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state == ST_WAIT_REF && !ref_present |=> !cal_active)
      else $error("calibration without reference");
   a_src_cleared: assert property (@(posedge clk_sys) disable iff (!rst_n)
      load_take |=> !reg2[`B2_SRC])
      else $error("source bit not cleared on reload");
   a_lock_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd && hit2 |=> rdata[`B2_LOCK] == $past(lock_pin))
      else $error("lock bit readback mismatch");
   a_pin_reload: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pin_rise |=> eeprom_reload && state == ST_WAIT_LOAD)
      else $error("pin pulse did not request reload");
endmodule

// *** rtl/pll_ctrl_cfg.svh ***
// Purpose: constants for the pll lock and vco calibration control block
// Assumes: 32-bit register words, byte address = register index * 4
// Notes:   times are kept in their own unit and turned into clk_sys cycles
//
// Contract
// - range bit picks low or high vco
// - two prescaler bits give ratio 5/4/3/2
// - four-bit loop filter code, sixteen settings
// - codes 0-3 internal filter, fixed pump currents; code still drives code bits 1:0 to cp_current_sel
// - codes 4-15 external, low bits pick current
// - lock on pin and register 2 bit 6
// - compare input and feedback divider phases
// - two-bit window code 2.1/4.6/7.2/19.9 ns; code resolves all four to one clk_sys cycle
// - one bad cycle or slip drops lock
// - many good cycles needed before lock
// - power-up calibration after load and reference
// - calibration waits for reference clock presence; a restart from run enters calibration without checking ref_present
// - register 2 bits 7, 13, 20 control calibration
// - restart rising edge starts calibration, outputs off
// - power-down bit low disables all outputs
// - power-down bit rising calibrates then enables
// - pin pulse reloads, clears source, calibrates
`ifndef PLL_CTRL_CFG_SVH
`define PLL_CTRL_CFG_SVH
// register indices and bus address width
`define ADDR_W        4
`define REG_IDX_0     2'h0
`define REG_IDX_1     2'h1
`define REG_IDX_2     2'h2
// field positions
`define B0_WIN_LO     13
`define B0_WIN_HI     14
`define B1_VCO        0
`define B1_PRESC_A    9
`define B1_PRESC_B    10
`define B1_LF_LSB     24
`define B1_LF_MSB     27
`define B2_LOCK       6
`define B2_PWR        7
`define B2_SRC        13
`define B2_RST        20
// reset values, power-down bit idles high (inactive)
`define REG0_RST      32'h0000_0000
`define REG1_RST      32'h0000_0000
`define REG2_RST      32'h0000_0080
// timing
`define CLK_PERIOD_PS 20000
`define WIN_PS_0      2100
`define WIN_PS_1      4600
`define WIN_PS_2      7200
`define WIN_PS_3      19900
`define CAL_PFD_CYCLES 550
`define LOCK_COUNT_DEF 64
`endif

// *** rtl/pll_ctrl_pkg.sv ***
// Purpose: types shared by the pll control modules
// Assumes: nothing beyond the cfg header
// Notes:   states carry no explicit codes
package pll_ctrl_pkg;
   typedef enum logic [2:0] {ST_WAIT_LOAD, ST_WAIT_REF, ST_CAL, ST_RUN, ST_POWERDOWN} cal_state_e;
   typedef struct packed {
      logic       internal;  // internal filter network in use
      logic [1:0] cp_sel;    // charge pump current select
      logic [1:0] rc_group;  // external resistor/capacitor group
   } lf_cfg_s;
endpackage

// *** rtl/lock_if.sv ***
// Purpose: carrier between the controller and the lock detector
// Assumes: all signals in the clk_sys domain
// Notes:   edges are one-cycle pulses
interface lock_if;
   logic       ref_edge;  // input divider rising edge
   logic       fb_edge;   // feedback divider rising edge
   logic [1:0] win_code;  // lock window code
   logic       clear;     // force unlocked
   logic       locked;    // lock indication
   modport ctl (output ref_edge, fb_edge, win_code, clear, input locked);
   modport det (input ref_edge, fb_edge, win_code, clear, output locked);
endinterface

// *** rtl/lock_detector.sv ***
// Purpose: phase window lock detector with successive-cycle qualification
// Assumes: divider clocks arrive as one-cycle edge pulses
// Notes:   windows under one clk_sys period resolve to one cycle
`include "pll_ctrl_cfg.svh"
module lock_detector
   import pll_ctrl_pkg::*;
#(
   parameter int LOCK_COUNT = `LOCK_COUNT_DEF
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // detector side of the carrier
   lock_if.det       lk
);
   localparam int CNT_W = 8;
   initial begin
      if (LOCK_COUNT < 1 || LOCK_COUNT > 255) $error("LOCK_COUNT out of range");
   end

   // longest time rounds down, never below one cycle
   function automatic logic [CNT_W-1:0] win_cycles(input logic [1:0] code);
      int ps;
      int c;
      ps = (code == 2'h0) ? `WIN_PS_0 : (code == 2'h1) ? `WIN_PS_1 :
           (code == 2'h2) ? `WIN_PS_2 : `WIN_PS_3;
      c = ps / `CLK_PERIOD_PS;
      win_cycles = (c < 1) ? CNT_W'(1) : CNT_W'(c);
   endfunction

   logic [CNT_W-1:0] since_ref;  // cycles since input divider edge
   logic [CNT_W-1:0] since_fb;   // cycles since feedback edge
   logic [1:0]       fb_cnt;     // feedback edges this reference period
   logic             phase_ok;   // feedback landed inside window after ref
   logic             seen_ref;   // first ref edge opens evaluation
   logic [CNT_W-1:0] run;        // successive good comparisons
   logic             locked;     // lock flag

   wire logic [CNT_W-1:0] win   = win_cycles(lk.win_code);
   wire logic [2:0] fb_total    = {1'b0, fb_cnt} + {2'h0, lk.fb_edge};
   // a period with other than one feedback edge counts as a slip
   wire logic slip              = (fb_total != 3'h1);
   wire logic in_win            = phase_ok || lk.fb_edge || (since_fb <= win);
   wire logic eval              = lk.ref_edge && seen_ref;
   wire logic good              = eval && !slip && in_win;
   wire logic bad               = eval && !good;
   wire logic [CNT_W-1:0] run_inc = (run == {CNT_W{1'b1}}) ? run : run + CNT_W'(1);

   assign lk.locked = locked;

   // phase bookkeeping between the two divider edges
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         since_ref <= '0;
         since_fb  <= '0;
         fb_cnt    <= 2'h0;
         phase_ok  <= 1'b0;
         seen_ref  <= 1'b0;
      end else begin
         since_ref <= lk.ref_edge ? '0 : ((since_ref == {CNT_W{1'b1}}) ? since_ref : since_ref + CNT_W'(1));
         since_fb  <= lk.fb_edge ? '0 : ((since_fb == {CNT_W{1'b1}}) ? since_fb : since_fb + CNT_W'(1));
         if (lk.ref_edge) begin
            fb_cnt   <= 2'h0;
            phase_ok <= 1'b0;
            seen_ref <= 1'b1;
         end else if (lk.fb_edge) begin
            fb_cnt   <= (fb_cnt == 2'h3) ? fb_cnt : fb_cnt + 2'h1;
            phase_ok <= (since_ref <= win);
         end
      end
   end

   // lock qualification: rises slowly, falls at once
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         run    <= '0;
         locked <= 1'b0;
      end else if (lk.clear || bad) begin
         run    <= '0;
         locked <= 1'b0;
      end else if (good) begin
         run    <= run_inc;
         locked <= (run_inc >= CNT_W'(LOCK_COUNT));
      end
   end

   sequence bad_cmp;
      bad && !lk.clear;
   endsequence
   a_drop_on_bad: assert property (@(posedge clk_sys) disable iff (!rst_n) bad_cmp |=> !locked)
      else $error("lock held after a bad comparison");
   a_lock_qualified: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(locked) |-> $past(good) && run >= CNT_W'(LOCK_COUNT))
      else $error("lock declared without enough good cycles");
   // a feedback edge landing past the window must never mark the phase good
   a_late_fb_rejected: assert property (@(posedge clk_sys) disable iff (!rst_n)
      lk.fb_edge && !lk.ref_edge && since_ref > win |=> !phase_ok)
      else $error("late feedback edge marked in window");
endmodule

// *** testbench/clock_nvm_model.sv ***
// Purpose: far-side model, divider clocks and nonvolatile memory answer
// Assumes: divider period of 8 clk_sys cycles, slower than clk_sys/2
// Notes:   dividers stand still at 0 while ref_run is low
module clock_nvm_model (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // controls from the bench
   input  wire logic       ref_run,
   input  wire logic [2:0] fb_skew,
   // memory handshake
   input  wire logic       eeprom_reload,
   output logic            load_done,
   // divider clocks
   output logic            ref_div,
   output logic            fb_div
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] phase;     // divider phase
   logic [1:0] wait_cnt;  // memory access time
   wire  [2:0] fb_phase = phase - fb_skew;  // skew moves the feedback edge away
   // phase counter, frozen while no reference runs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phase <= 3'h0;
      end else if (ref_run) begin
         phase <= phase + 3'h1;
      end
   end
   assign ref_div = ref_run & ~phase[2];
   assign fb_div  = ref_run & ~fb_phase[2];
   // a pending load is answered after four cycles, as a one-cycle pulse
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wait_cnt  <= 2'h0;
         load_done <= 1'b0;
      end else begin
         load_done <= eeprom_reload & (wait_cnt == 2'h3);
         wait_cnt  <= eeprom_reload ? wait_cnt + 2'h1 : 2'h0;
      end
   end
endmodule

// *** testbench/pll_lock_and_vco_calibration_control_bench.sv ***
// Purpose: self-checking bench for the pll control block
// Assumes: CAL_CYCLES 4 and LOCK_COUNT 2 keep runs short
// Notes:   register model m mirrors writes and memory loads
module pll_lock_and_vco_calibration_control_bench;
   import pll_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys = 0, rst_n = 0, wr = 0, rd = 0, ref_present = 0, pin_n = 1, ref_run = 0;
   logic [3:0]  addr = 0;
   logic [31:0] wdata = 0, rdata, w0 = 0, w1 = 0, w2 = 0;
   logic [2:0]  fb_skew = 0, ratio;
   logic        eeprom_reload, load_done, ref_div, fb_div, vco, lf_int, out_en, cal, lock_pin;
   logic [1:0]  cp, rc, win;
   logic [31:0] m [3];  // register model
   int          mismatches = 0, compares = 0, seed = 32'h35fe95b6;
   always #10 clk_sys = ~clk_sys;
   pll_lock_and_vco_calibration_control #(.CAL_CYCLES(4), .LOCK_COUNT(2)) i_pll_lock_and_vco_calibration_control (
      .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .eeprom_reload(eeprom_reload), .load_done(load_done), .eeprom_word0(w0), .eeprom_word1(w1),
      .eeprom_word2(w2), .ref_present(ref_present), .ref_div(ref_div), .fb_div(fb_div),
      .power_down_pin_n(pin_n), .vco_range_select(vco), .prescale_ratio(ratio), .lf_internal(lf_int),
      .cp_current_sel(cp), .lf_rc_group(rc), .lock_window_code(win), .out_enable(out_en),
      .cal_active(cal), .lock_pin(lock_pin));
   clock_nvm_model i_clock_nvm_model (.clk_sys(clk_sys), .rst_n(rst_n), .ref_run(ref_run), .fb_skew(fb_skew),
      .eeprom_reload(eeprom_reload), .load_done(load_done), .ref_div(ref_div), .fb_div(fb_div));
   // verdict and end of run
   task automatic complete_run;
      if (mismatches == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // one comparison, x never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // settle n edges, then sample
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // one-cycle write, model follows mapped words only
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wr <= 1'b0;
      if (a < 4'hc) m[a[3:2]] = d;
   endtask
   // one-cycle read, data taken in the following cycle only
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // read and compare against the model, lock bit masked off
   task automatic rd_chk(input logic [3:0] a);
      logic [31:0] v;
      rd_reg(a, v);
      chk(v & ~32'h40, ((a < 4'hc) ? m[a[3:2]] : 32'h0) & ~32'h40);
   endtask
   // bounded wait for the outputs to come back on
   task automatic wait_run;
      int n;
      n = 0;
      while (out_en !== 1'b1 && n < 2000) begin
         @(posedge clk_sys);
         #1 n++;
      end
      if (n >= 2000) begin
         mismatches++;
         complete_run;
      end
   endtask
   // decoded configuration outputs against the model
   task automatic check_cfg;
      chk(vco, m[1][0]);
      chk(ratio, 5 - (m[1][10] + 2 * m[1][9]));
      chk(lf_int, m[1][27:24] < 4);
      chk({rc, cp}, m[1][27:24]);
      chk(win, m[0][14:13]);
   endtask
   // main sequence
   initial begin
      logic [31:0] d;
      w0 <= $random(seed);
      w1 <= $random(seed);
      w2 <= 32'h0000_2080;  // source bit set in memory, must load as 0
      repeat (11) @(posedge clk_sys);
      #1 chk(ratio, 5);
      chk(lf_int, 1);
      chk(eeprom_reload, 1);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      m[0] = w0;
      m[1] = w1;
      m[2] = w2 & ~32'h2000;
      cyc(30);
      chk(eeprom_reload, 0);
      chk(cal, 0);
      @(posedge clk_sys);
      ref_present <= 1'b1;
      ref_run <= 1'b1;
      cyc(4);
      chk(cal, 1);
      wait_run;
      for (int k = 0; k < 4; k++) rd_chk(4'(k * 4));
      // every loop filter code with random neighbours
      for (int i = 0; i < 16; i++) begin
         d = $random(seed);
         d[27:24] = i[3:0];
         wr_reg(4'h4, d);
         wr_reg(4'h0, $random(seed));
         wr_reg(4'hc, $random(seed));
         cyc(2);
         check_cfg;
      end
      // settings changed, so recalibrate by restart edge
      wr_reg(4'h8, 32'h0010_2080);
      cyc(3);
      chk({cal, out_en}, 2'b10);
      wait_run;
      wr_reg(4'h8, 32'h0010_2080);
      cyc(4);
      chk(cal, 0);
      wr_reg(4'h8, 32'h0000_2080);
      wr_reg(4'h8, 32'h0010_2080);
      cyc(3);
      chk(cal, 1);
      wait_run;
      cyc(40);
      chk(lock_pin, 1);
      rd_reg(4'h8, d);
      chk(d & 32'h40, 32'h40);
      @(posedge clk_sys);
      fb_skew <= 3'h3;
      cyc(24);
      chk(lock_pin, 0);
      @(posedge clk_sys);
      fb_skew <= 3'h0;
      // power-down bit with source clear
      wr_reg(4'h8, 32'h0000_0080);
      wr_reg(4'h8, 32'h0000_0000);
      cyc(3);
      chk(out_en, 0);
      cyc(50);
      chk({cal, out_en}, 2'b00);
      wr_reg(4'h8, 32'h0000_0080);
      cyc(5);
      chk(cal, 1);
      wait_run;
      chk(cal, 0);
      // pin pulse reloads memory and clears the source bit
      wr_reg(4'h8, 32'h0000_2080);
      @(posedge clk_sys);
      w1 <= $random(seed);
      pin_n <= 1'b0;
      cyc(3);
      chk(out_en, 0);
      @(posedge clk_sys);
      pin_n <= 1'b1;
      cyc(2);
      chk(eeprom_reload, 1);
      m[0] = w0;
      m[1] = w1;
      m[2] = w2 & ~32'h2000;
      wait_run;
      for (int k = 0; k < 3; k++) rd_chk(4'(k * 4));
      check_cfg;
      complete_run;
   end
endmodule
